// file: icm_cfg.svh
// Offsets, field positions, reset values and masks for the interrupt clear and monitor bypass block.
// Assumes byte-wide registers on a 16-bit address port; included by every file that needs them.
`ifndef ICM_CFG_SVH
`define ICM_CFG_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define ICM_ADDR_BYPASS 16'h2004
`define ICM_ADDR_CMD 16'h2005
`define ICM_ADDR_CLR_TB 16'h2006
`define ICM_ADDR_CLR_AUX 16'h2007
`define ICM_ADDR_CLR_REF_INPUT_A 16'h2008
`define ICM_ADDR_CLR_REF_INPUT_B 16'h2009
`define ICM_ADDR_STAT_TB 16'h3006
`define ICM_ADDR_STAT_AUX 16'h3007
`define ICM_ADDR_STAT_REF_INPUT_A 16'h3008
`define ICM_ADDR_STAT_REF_INPUT_B 16'h3009
`define ICM_ADDR_STAT_CH0 16'h300a
`define ICM_ADDR_STAT_CH1 16'h300b
`define ICM_ADDR_EN_TB 16'h3106
`define ICM_ADDR_EN_AUX 16'h3107
`define ICM_ADDR_EN_REF_INPUT_A 16'h3108
`define ICM_ADDR_EN_REF_INPUT_B 16'h3109
`define ICM_ADDR_EN_CH0 16'h310a
`define ICM_ADDR_EN_CH1 16'h310b
`define ICM_ADDR_NONE 16'hffff

// ----------------------------------------------------------------------------
// Command register fields
// ----------------------------------------------------------------------------
`define ICM_CMD_WDOG 7
`define ICM_CMD_CH1 3
`define ICM_CMD_CH0 2
`define ICM_CMD_COMMON 1
`define ICM_CMD_ALL 0

// ----------------------------------------------------------------------------
// Bypass register fields: one bit per reference input
// ----------------------------------------------------------------------------
`define ICM_BYP_REF_A 0
`define ICM_BYP_REF_A_SECOND 1
`define ICM_BYP_REF_B 2
`define ICM_BYP_REF_B_SECOND 3
`define ICM_BYP_MASK 8'h0f

// ----------------------------------------------------------------------------
// Masks and reset values
// ----------------------------------------------------------------------------
`define ICM_FULL_MASK 8'hff
`define ICM_AUX_MASK 8'h3f
`define ICM_RST_BYTE 8'h00
`define ICM_RST_REFS 4'h0

`endif

// file: icm_event_bank.sv
// One bank of sticky event flags with enable gating.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/1ps
`include "icm_cfg.svh"

module icm_event_bank #(
  parameter int WIDTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] evt_set,
  input wire logic [WIDTH-1:0] evt_clr,
  input wire logic [WIDTH-1:0] evt_enable,
  output logic [WIDTH-1:0] evt_status,
  output logic evt_pending
);

  // ----------------------------------------------------------------------------
  // Sticky flags
  // ----------------------------------------------------------------------------
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_flag
    always_ff @(posedge ref_clk or posedge rst)
    begin
      if (rst)
        evt_status[i] <= 1'b0;
      // A new event beats a clear in the same cycle so it is never lost
      else if (evt_set[i])
        evt_status[i] <= 1'b1;
      else if (evt_clr[i])
        evt_status[i] <= 1'b0; // see [R17]
    end
  end

  assign evt_pending = |(evt_status & evt_enable);

endmodule : icm_event_bank

// file: icm_monitor_bypass.sv
// Frequency monitor fault masking for the reference inputs.
// Assumes monitor results arrive on the same clock.
`timescale 1ns/1ps
`include "icm_cfg.svh"

module icm_monitor_bypass #(
  parameter int NUM_REFS = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [NUM_REFS-1:0] mon_fault,
  input wire logic [NUM_REFS-1:0] bypass,
  output logic [NUM_REFS-1:0] ref_faulted
);

  // ----------------------------------------------------------------------------
  // Masked fault report
  // ----------------------------------------------------------------------------
  // Only the fault is hidden; validation stays with the reference logic
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      ref_faulted <= '0;
    else
      ref_faulted <= mon_fault & ~bypass; // see [R1] see [R2] see [R3] see [R4]
  end

endmodule : icm_monitor_bypass

// file: icm_pkg.sv
// Types shared by the interrupt clear and monitor bypass block.
// Assumes nothing beyond a SystemVerilog compiler.
package icm_pkg;

  // ----------------------------------------------------------------------------
  // Basic types
  // ----------------------------------------------------------------------------
  typedef logic [7:0] icm_byte_t;
  typedef logic [15:0] icm_addr_t;
  typedef logic [3:0] icm_refs_t;

  // ----------------------------------------------------------------------------
  // Event banks, in array order
  // ----------------------------------------------------------------------------
  typedef enum {
    icm_bank_tb,
    icm_bank_aux,
    icm_bank_ref_input_a,
    icm_bank_ref_input_b,
    icm_bank_ch0,
    icm_bank_ch1
  } icm_bank_t;

  localparam int ICM_NUM_BANKS = 6;

endpackage : icm_pkg

// file: icm_top.sv
// Interrupt clear command, common event clear banks and reference monitor bypass.
// Assumes one clock, a single-cycle register port and event pulses on the same clock.
//
// Summary of operation
// [R1] Bypass bit 2 hides the monitor fault of reference input B and reports it unfaulted.
// [R2] Bypass bit 1 hides the monitor fault of reference input A second and reports it unfaulted.
// [R3] Bypass bit 0 hides the monitor fault of reference input A and reports it unfaulted.
// [R4] A bypass bit only clears the fault report and never makes a reference valid by itself.
// [R5] Software forces a reference valid by bypass, unforced fault, transfer, timeout bit, transfer.
// [R6] Writing one to command bit 7 pulses the watchdog restart for one cycle, starting the cycle after the write.
// [R7] Writing one to command bit 3 clears every pending loop channel 1 event.
// [R8] Writing one to command bit 2 clears every pending loop channel 0 event.
// [R9] Writing one to command bit 1 clears the common event group.
// [R10] Writing one to command bit 0 clears every pending event in all groups.
// [R11] The command strobes last one cycle and read back as zero.
// [R12] Timebase clear bit 7 clears the timebase-unlocked event.
// [R13] Timebase clear bits 6 and 5 clear the stabilized and locked events.
// [R14] Timebase clear bits 4 to 0 clear calibration done, calibration start, watchdog, nv fault, nv done.
// [R15] Aux loop clear bits 5 to 0 clear skew, temperature, unfaulted, faulted, unlocked, locked; 7:6 reserved.
// [R16] Each reference clear register serves the second input in its upper nibble, the first in its lower.
// [R17] Writing zero to a clear bit changes nothing, and all clear registers reset to zero.
`timescale 1ns/1ps
`include "icm_cfg.svh"

module icm_top #(
  parameter int NUM_REFS = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire icm_pkg::icm_addr_t reg_addr,
  input wire icm_pkg::icm_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output icm_pkg::icm_byte_t reg_rdata,
  input wire icm_pkg::icm_byte_t timebase_evt,
  input wire logic [5:0] aux_loop_evt,
  input wire icm_pkg::icm_byte_t ref_pair_a_evt,
  input wire icm_pkg::icm_byte_t ref_pair_b_evt,
  input wire icm_pkg::icm_byte_t loop_channel_0_evt,
  input wire icm_pkg::icm_byte_t loop_channel_1_evt,
  input wire logic [NUM_REFS-1:0] freq_mon_fault,
  output logic [NUM_REFS-1:0] ref_faulted,
  output logic wdog_restart,
  output logic irq
);
  import icm_pkg::*;

  // ----------------------------------------------------------------------------
  // Address decoding
  // ----------------------------------------------------------------------------
  function automatic icm_addr_t clear_addr(input int b);
    unique case (b)
      int'(icm_bank_tb): clear_addr = `ICM_ADDR_CLR_TB;
      int'(icm_bank_aux): clear_addr = `ICM_ADDR_CLR_AUX;
      int'(icm_bank_ref_input_a): clear_addr = `ICM_ADDR_CLR_REF_INPUT_A;
      int'(icm_bank_ref_input_b): clear_addr = `ICM_ADDR_CLR_REF_INPUT_B;
      // Loop channel banks are cleared by the command strobes and by a write to ICM_ADDR_NONE
      default: clear_addr = `ICM_ADDR_NONE;
    endcase
  endfunction : clear_addr

  function automatic icm_addr_t status_addr(input int b);
    unique case (b)
      int'(icm_bank_tb): status_addr = `ICM_ADDR_STAT_TB;
      int'(icm_bank_aux): status_addr = `ICM_ADDR_STAT_AUX;
      int'(icm_bank_ref_input_a): status_addr = `ICM_ADDR_STAT_REF_INPUT_A;
      int'(icm_bank_ref_input_b): status_addr = `ICM_ADDR_STAT_REF_INPUT_B;
      int'(icm_bank_ch0): status_addr = `ICM_ADDR_STAT_CH0;
      int'(icm_bank_ch1): status_addr = `ICM_ADDR_STAT_CH1;
      default: status_addr = `ICM_ADDR_NONE;
    endcase
  endfunction : status_addr

  function automatic icm_addr_t enable_addr(input int b);
    unique case (b)
      int'(icm_bank_tb): enable_addr = `ICM_ADDR_EN_TB;
      int'(icm_bank_aux): enable_addr = `ICM_ADDR_EN_AUX;
      int'(icm_bank_ref_input_a): enable_addr = `ICM_ADDR_EN_REF_INPUT_A;
      int'(icm_bank_ref_input_b): enable_addr = `ICM_ADDR_EN_REF_INPUT_B;
      int'(icm_bank_ch0): enable_addr = `ICM_ADDR_EN_CH0;
      int'(icm_bank_ch1): enable_addr = `ICM_ADDR_EN_CH1;
      default: enable_addr = `ICM_ADDR_NONE;
    endcase
  endfunction : enable_addr

  // Reserved aux bits never clear anything
  function automatic icm_byte_t bank_mask(input int b);
    if (b == int'(icm_bank_aux))
      bank_mask = `ICM_AUX_MASK; // see [R15]
    else
      bank_mask = `ICM_FULL_MASK;
  endfunction : bank_mask

  // ----------------------------------------------------------------------------
  // Command strobes
  // ----------------------------------------------------------------------------
  logic cmd_wr;
  logic clr_all;
  logic clr_common;
  logic clr_ch0;
  logic clr_ch1;

  // Strobes are decoded straight from the write, so nothing is stored to read back
  assign cmd_wr = reg_wr && (reg_addr == `ICM_ADDR_CMD); // see [R11]
  assign clr_all = cmd_wr && reg_wdata[`ICM_CMD_ALL]; // see [R10]
  assign clr_common = cmd_wr && reg_wdata[`ICM_CMD_COMMON]; // see [R9]
  assign clr_ch0 = cmd_wr && reg_wdata[`ICM_CMD_CH0]; // see [R8]
  assign clr_ch1 = cmd_wr && reg_wdata[`ICM_CMD_CH1]; // see [R7]

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      wdog_restart <= 1'b0;
    else
      wdog_restart <= cmd_wr && reg_wdata[`ICM_CMD_WDOG]; // see [R6]
  end

  // ----------------------------------------------------------------------------
  // Monitor bypass
  // ----------------------------------------------------------------------------
  logic [NUM_REFS-1:0] bypass;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      bypass <= '0;
    else if (reg_wr && (reg_addr == `ICM_ADDR_BYPASS))
      bypass <= reg_wdata[NUM_REFS-1:0];
  end

  icm_monitor_bypass #(
    .NUM_REFS(NUM_REFS)
  ) u_bypass (
    .ref_clk(ref_clk),
    .rst(rst),
    .mon_fault(freq_mon_fault),
    .bypass(bypass),
    .ref_faulted(ref_faulted)
  );

  // ----------------------------------------------------------------------------
  // Event banks
  // ----------------------------------------------------------------------------
  icm_byte_t evt_in [ICM_NUM_BANKS];
  icm_byte_t evt_clr [ICM_NUM_BANKS];
  icm_byte_t evt_en [ICM_NUM_BANKS];
  icm_byte_t evt_stat [ICM_NUM_BANKS];
  logic [ICM_NUM_BANKS-1:0] bank_pending;

  // Bit order follows the clear registers directly
  assign evt_in[icm_bank_tb] = timebase_evt; // see [R12] see [R13] see [R14]
  assign evt_in[icm_bank_aux] = {2'b00, aux_loop_evt}; // see [R15]
  assign evt_in[icm_bank_ref_input_a] = ref_pair_a_evt; // see [R16]
  assign evt_in[icm_bank_ref_input_b] = ref_pair_b_evt; // see [R16]
  assign evt_in[icm_bank_ch0] = loop_channel_0_evt;
  assign evt_in[icm_bank_ch1] = loop_channel_1_evt;

  for (genvar b = 0; b < ICM_NUM_BANKS; b++)
  begin : g_bank
    logic group_clr;
    logic is_common;

    assign is_common = (b <= int'(icm_bank_ref_input_b));
    assign group_clr = clr_all
      || (clr_common && is_common)
      || (clr_ch0 && (b == int'(icm_bank_ch0)))
      || (clr_ch1 && (b == int'(icm_bank_ch1)));

    // Only ones clear; a zero bit leaves its flag as it was
    assign evt_clr[b] = (group_clr ? `ICM_FULL_MASK : `ICM_RST_BYTE)
      | ((reg_wr && (reg_addr == clear_addr(b))) ? (reg_wdata & bank_mask(b)) : `ICM_RST_BYTE); // see [R17]

    always_ff @(posedge ref_clk or posedge rst)
    begin
      if (rst)
        evt_en[b] <= `ICM_RST_BYTE;
      else if (reg_wr && (reg_addr == enable_addr(b)))
        evt_en[b] <= reg_wdata & bank_mask(b);
    end

    icm_event_bank #(
      .WIDTH(8)
    ) u_bank (
      .ref_clk(ref_clk),
      .rst(rst),
      .evt_set(evt_in[b] & bank_mask(b)),
      .evt_clr(evt_clr[b]),
      .evt_enable(evt_en[b]),
      .evt_status(evt_stat[b]),
      .evt_pending(bank_pending[b])
    );
  end

  assign irq = |bank_pending;

  // ----------------------------------------------------------------------------
  // Read back
  // ----------------------------------------------------------------------------
  icm_byte_t next_rdata;

  always_comb
  begin
    next_rdata = `ICM_RST_BYTE;
    if (reg_addr == `ICM_ADDR_BYPASS)
      next_rdata = {{(8-NUM_REFS){1'b0}}, bypass};
    for (int b = 0; b < ICM_NUM_BANKS; b++)
    begin
      if (reg_addr == status_addr(b))
        next_rdata = evt_stat[b];
      if (reg_addr == enable_addr(b))
        next_rdata = evt_en[b];
    end
    // Command and clear registers are pure strobes and fall through as zero
  end

  // Data is held for the one cycle after the read only
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= `ICM_RST_BYTE;
    else if (reg_rd)
      reg_rdata <= next_rdata; // see [R11]
    else
      reg_rdata <= `ICM_RST_BYTE;
  end

endmodule : icm_top

// file: icm_top_monitor.sv
// Concurrent checks on the watchdog, readback, bypass and clear ports of icm_top.
// Assumes one clock, asynchronous reset and the one-cycle register port.
`timescale 1ns/1ps
`include "icm_cfg.svh"

module icm_top_monitor #(
  parameter int NUM_REFS = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire icm_pkg::icm_addr_t reg_addr,
  input wire icm_pkg::icm_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire icm_pkg::icm_byte_t reg_rdata,
  input wire icm_pkg::icm_byte_t timebase_evt,
  input wire logic [5:0] aux_loop_evt,
  input wire icm_pkg::icm_byte_t ref_pair_a_evt,
  input wire icm_pkg::icm_byte_t ref_pair_b_evt,
  input wire icm_pkg::icm_byte_t loop_channel_0_evt,
  input wire icm_pkg::icm_byte_t loop_channel_1_evt,
  input wire logic [NUM_REFS-1:0] freq_mon_fault,
  input wire logic [NUM_REFS-1:0] ref_faulted,
  input wire logic wdog_restart,
  input wire logic irq
);
  import icm_pkg::*;
  // ------------------------------------------------------------
  // Helper state
  // ------------------------------------------------------------
  // Shadow of the bypass bits, so fault masking is judged per bit
  logic live;
  logic [NUM_REFS-1:0] byp;
  wire [NUM_REFS-1:0] mon_ok = freq_mon_fault & ~byp;
  wire wdog_wr = reg_wr && reg_addr == `ICM_ADDR_CMD && reg_wdata[`ICM_CMD_WDOG];
  wire any_evt = |{timebase_evt, aux_loop_evt, ref_pair_a_evt, ref_pair_b_evt, loop_channel_0_evt, loop_channel_1_evt};
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      live <= 1'b0;
    else
      live <= 1'b1;
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      byp <= '0;
    else if (reg_wr && reg_addr == `ICM_ADDR_BYPASS)
      byp <= reg_wdata[NUM_REFS-1:0];
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence one_pulse;
    wdog_restart ##1 !wdog_restart;
  endsequence
  wdog_pulse_a: assert property (wdog_wr |=> one_pulse) else $error("watchdog restart pulse wrong");
  wdog_cause_a: assert property (live && wdog_restart |-> $past(wdog_wr)) else $error("stray restart");
  clr_read_a: assert property (reg_rd && reg_addr inside {[`ICM_ADDR_CMD:`ICM_ADDR_CLR_REF_INPUT_B]} |=>
    reg_rdata == 8'h00) else $error("clear register read nonzero");
  rdata_idle_a: assert property (live && !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data lingers");
  byp_b_a: assert property (live |-> ref_faulted[2] == $past(mon_ok[2])) else $error("input b fault");
  byp_second_a: assert property (live |-> ref_faulted[1] == $past(mon_ok[1])) else $error("input a2 fault");
  byp_a_a: assert property (live |-> ref_faulted[0] == $past(mon_ok[0])) else $error("input a fault");
  clr_all_a: assert property (reg_wr && reg_addr == `ICM_ADDR_CMD && reg_wdata[`ICM_CMD_ALL] && !any_evt
    |=> !irq) else $error("irq after clear all");
  zero_clr_a: assert property (reg_wr && reg_addr == `ICM_ADDR_CLR_TB && reg_wdata == 8'h00 && !any_evt
    |=> $stable(irq)) else $error("zero clear changed irq");
endmodule : icm_top_monitor

bind icm_top icm_top_monitor #(.NUM_REFS(NUM_REFS)) icm_top_monitor_i (.ref_clk(ref_clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .timebase_evt(timebase_evt), .aux_loop_evt(aux_loop_evt), .ref_pair_a_evt(ref_pair_a_evt),
  .ref_pair_b_evt(ref_pair_b_evt), .loop_channel_0_evt(loop_channel_0_evt), .loop_channel_1_evt(loop_channel_1_evt),
  .freq_mon_fault(freq_mon_fault), .ref_faulted(ref_faulted), .wdog_restart(wdog_restart), .irq(irq));

// file: tb_top.sv
// Self-checking bench for icm_top: readback, bypass, watchdog, bank clears and group clears.
// Assumes a 250 MHz clock and the one-cycle register port.
`timescale 1ns/1ps
`include "icm_cfg.svh"

module tb_top;
  import icm_pkg::*;
  // ------------------------------------------------------------
  // Stimulus and design
  // ------------------------------------------------------------
  localparam icm_byte_t MSK [6] = '{8'hff, `ICM_AUX_MASK, 8'hff, 8'hff, 8'hff, 8'hff};
  // Banks cleared by command bits 0 to 3
  localparam logic [5:0] SCOPE [4] = '{6'h3f, 6'h0f, 6'h10, 6'h20};
  logic ref_clk, rst, reg_wr, reg_rd, wdr, irq;
  icm_addr_t reg_addr;
  icm_byte_t reg_wdata, reg_rdata;
  icm_byte_t ev [6];
  logic [3:0] fmf, rf;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  icm_top icm_top_i (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timebase_evt(ev[0]), .aux_loop_evt(ev[1][5:0]),
    .ref_pair_a_evt(ev[2]), .ref_pair_b_evt(ev[3]), .loop_channel_0_evt(ev[4]), .loop_channel_1_evt(ev[5]),
    .freq_mon_fault(fmf), .ref_faulted(rf), .wdog_restart(wdr), .irq(irq));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input icm_addr_t a, input icm_byte_t d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input icm_addr_t a, input icm_byte_t exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk("rdata", exp, reg_rdata);
  endtask : rd
  // One-cycle pulse on every event input at once
  task automatic fill();
    @(posedge ref_clk);
    foreach (ev[b]) ev[b] <= 8'hff;
    @(posedge ref_clk);
    foreach (ev[b]) ev[b] <= 8'h00;
    #1;
  endtask : fill
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    rd(`ICM_ADDR_BYPASS, 8'h00);
    rd(`ICM_ADDR_NONE, 8'h00);
    for (int b = 0; b < 6; b++)
    begin
      rd(`ICM_ADDR_STAT_TB + 16'(b), 8'h00);
      rd(`ICM_ADDR_EN_TB + 16'(b), 8'h00);
    end
    chk("irq", 8'h00, {7'h00, irq});
  endtask : t_reset
  task automatic t_bypass();
    @(posedge ref_clk);
    fmf <= 4'hf;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("ref_faulted", 8'h0f, {4'h0, rf});
    for (int i = 0; i < 4; i++)
    begin
      wr(`ICM_ADDR_BYPASS, 8'(1 << i));
      @(posedge ref_clk);
      #1;
      chk("ref_faulted", 8'h0f & ~8'(1 << i), {4'h0, rf});
    end
    wr(`ICM_ADDR_BYPASS, 8'hff);
    rd(`ICM_ADDR_BYPASS, `ICM_BYP_MASK);
    wr(`ICM_ADDR_BYPASS, 8'h00);
  endtask : t_bypass
  task automatic t_wdog();
    wr(`ICM_ADDR_CMD, 8'h80);
    chk("wdog_restart", 8'h01, {7'h00, wdr});
    @(posedge ref_clk);
    #1;
    chk("wdog_restart", 8'h00, {7'h00, wdr});
    rd(`ICM_ADDR_CMD, 8'h00);
  endtask : t_wdog
  // Each common bank: set, mask, zero write, then clear one bit at a time
  task automatic t_bank();
    for (int b = 0; b < 4; b++)
    begin
      wr(`ICM_ADDR_EN_TB + 16'(b), 8'hff);
      fill();
      chk("irq", 8'h01, {7'h00, irq});
      wr(`ICM_ADDR_EN_TB + 16'(b), 8'h00);
      chk("irq", 8'h00, {7'h00, irq});
      wr(`ICM_ADDR_EN_TB + 16'(b), 8'hff);
      wr(`ICM_ADDR_CLR_TB + 16'(b), 8'h00);
      rd(`ICM_ADDR_STAT_TB + 16'(b), MSK[b]);
      for (int i = 0; i < 8; i++)
      begin
        wr(`ICM_ADDR_CLR_TB + 16'(b), 8'(1 << i));
        rd(`ICM_ADDR_STAT_TB + 16'(b), MSK[b] & ~8'((2 << i) - 1));
      end
      rd(`ICM_ADDR_CLR_TB + 16'(b), 8'h00);
      chk("irq", 8'h00, {7'h00, irq});
      // Fill sets every bank again, so this bank must not keep irq up for the next one
      wr(`ICM_ADDR_EN_TB + 16'(b), 8'h00);
    end
    wr(`ICM_ADDR_CMD, 8'h01);
  endtask : t_bank
  task automatic t_cmd();
    for (int b = 4; b < 6; b++)
      wr(`ICM_ADDR_EN_TB + 16'(b), 8'hff);
    for (int k = 3; k >= 0; k--)
    begin
      fill();
      chk("irq", 8'h01, {7'h00, irq});
      wr(`ICM_ADDR_CMD, 8'(1 << k));
      for (int b = 0; b < 6; b++)
        rd(`ICM_ADDR_STAT_TB + 16'(b), SCOPE[k][b] ? 8'h00 : MSK[b]);
      wr(`ICM_ADDR_CMD, 8'h01);
    end
    chk("irq", 8'h00, {7'h00, irq});
  endtask : t_cmd
  // ------------------------------------------------------------
  // Clock, sequence and hang guard
  // ------------------------------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial
  begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    fmf = 4'h0;
    foreach (ev[b]) ev[b] = 8'h00;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_bypass();
    t_wdog();
    t_bank();
    t_cmd();
    results();
  end
  // Whole run needs about 350 cycles; the ceiling leaves ample margin
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 10000)
    begin
      n_mismatch++;
      results();
    end
  end
endmodule : tb_top
